// ---- rtl/sadc_pkg.sv ----
package sadc_pkg;

   // ****************************************
   // widths
   // ****************************************
   localparam int RES_W  = 10;
   localparam int CNT_W  = 5;
   localparam int TMR_W  = 8;
   localparam int GRAY_W = 4;
   localparam int CSC_W  = 4;

   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_NS       = 100;
   localparam int CS_VALID_NS  = 1425;
   localparam int SYNC_WIN_NS  = 9500;
   localparam int CONV_WIN_NS  = 21000;
   localparam int CS_VALID_CYC = (CS_VALID_NS + CLK_NS - 1) / CLK_NS;
   localparam int SYNC_WIN_CYC = SYNC_WIN_NS / CLK_NS;
   localparam int CONV_WIN_CYC = CONV_WIN_NS / CLK_NS;
   localparam logic [CSC_W-1:0] CS_CNT_LAST = CSC_W'(CS_VALID_CYC - 1);
   localparam logic [TMR_W-1:0] TMR_SYNC    = TMR_W'(SYNC_WIN_CYC);
   localparam logic [TMR_W-1:0] TMR_CONV    = TMR_W'(CONV_WIN_CYC);
   localparam int STEP_CYC_DEF = 10;

   // ****************************************
   // edge numbers within a transfer, and the result msb index
   // ****************************************
   localparam logic [CNT_W-1:0] EDGE_SAMPLE = 5'h03;
   localparam logic [CNT_W-1:0] EDGE_HOLD   = 5'h0a;
   localparam logic [CNT_W-1:0] EDGE_LAST   = 5'h10;
   localparam logic [3:0]       MSB_IDX     = 4'h9;

   // ****************************************
   // reset value and first trial weight
   // ****************************************
   localparam logic [RES_W-1:0] RESULT_RST = 10'h000;
   localparam logic [RES_W-1:0] MSB_WEIGHT = 10'h200;

   // ****************************************
   // frame states
   // ****************************************
   typedef enum logic [2:0]
   {
      ST_IDLE  = 3'b001,
      ST_SHIFT = 3'b010,
      ST_SPARE = 3'b100
   } sadc_st_t;

endpackage : sadc_pkg

// ---- rtl/sadc_sync.sv ----
`timescale 1ns/1ps

module sadc_sync
   import sadc_pkg::*;
#(
   parameter int           W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
)
(
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   typedef struct packed
   {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sadc_sync_t;

   sadc_sync_t r_q;
   sadc_sync_t r_d;

   always_comb
   begin
      r_d.s1 = d;
      r_d.s2 = r_q.s1;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         r_q <= {RST_VAL, RST_VAL};
      end
      else
      begin
         r_q <= r_d;
      end
   end

   assign q = r_q.s2;

endmodule : sadc_sync

// ---- rtl/sadc_sar.sv ----
`timescale 1ns/1ps

module sadc_sar
   import sadc_pkg::*;
#(
   parameter int STEP_CYC = STEP_CYC_DEF
)
(
   // clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   // control
   input  wire logic             start,
   input  wire logic             abort,
   input  wire logic             cmp_above,
   // status and data
   output logic                  busy,
   output logic [RES_W-1:0]      dac_code,
   output logic [RES_W-1:0]      result
);

   localparam logic [7:0] STEP_LAST = 8'(STEP_CYC - 1);

   typedef struct packed
   {
      logic             busy;
      logic [3:0]       idx;
      logic [7:0]       wcnt;
      logic [RES_W-1:0] code;
      logic [RES_W-1:0] result;
   } sadc_sar_t;

   sadc_sar_t q;
   sadc_sar_t d;

   // ****************************************
   // successive approximation
   // ****************************************
   always_comb
   begin
      logic [RES_W-1:0] trial;
      trial = q.code;
      d     = q;
      if (q.busy && cmp_above)
      begin
         trial[q.idx] = 1'b0;
      end
      if (abort)
      begin
         d.busy = 1'b0;
         d.code = RESULT_RST;
      end
      else if (start)
      begin
         d.busy = 1'b1;
         d.idx  = MSB_IDX;
         d.wcnt = 8'h00;
         d.code = MSB_WEIGHT;
      end
      else if (q.busy)
      begin
         if (q.wcnt == STEP_LAST)
         begin
            d.wcnt = 8'h00;
            if (q.idx == 4'h0)
            begin
               d.busy   = 1'b0;
               d.code   = trial;
               d.result = trial;
            end
            else
            begin
               d.idx                = q.idx - 4'h1;
               d.code               = trial;
               d.code[q.idx - 4'h1] = 1'b1;
            end
         end
         else
         begin
            d.wcnt = q.wcnt + 8'h01;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q <= '{busy: 1'b0, idx: 4'h0, wcnt: 8'h00, code: RESULT_RST, result: RESULT_RST};
      end
      else
      begin
         q <= d;
      end
   end

   assign busy     = q.busy;
   assign dac_code = q.code;
   assign result   = q.result;

endmodule : sadc_sar

// ---- rtl/sadc_top.sv ----
`timescale 1ns/1ps

module sadc_top
   import sadc_pkg::*;
#(
   parameter int STEP_CYC = STEP_CYC_DEF
)
(
   // system
   input  wire logic                    clk_sys,
   input  wire logic                    rst_n,
   // serial link
   input  wire logic                    cs_n,
   input  wire logic                    io_clk,
   output logic                         dout,
   output logic                         dout_oe,
   // analog front end
   input  wire logic                    cmp_above,
   output logic                         sample_en,
   output logic [sadc_pkg::RES_W-1:0]   dac_code,
   // status
   output logic                         conv_busy,
   output logic                         mode_slow,
   output logic [sadc_pkg::RES_W-1:0]   result
);

   import sadc_pkg::*;

   // ****************************************
   // state types
   // ****************************************
   typedef struct packed
   {
      sadc_st_t            st;
      logic [CNT_W-1:0]    cnt;
      logic [RES_W-1:0]    sh;
      logic                dout;
      logic                oe;
      logic                sample;
      logic [TMR_W-1:0]    tmr;
      logic                tmr_run;
      logic                pend;
      logic                slow;
      logic                cs_lvl;
      logic [CSC_W-1:0]    cs_cnt;
      logic [GRAY_W-1:0]   last_bin;
      logic                conv_start;
      logic                abort;
   } sadc_ctl_t;

   typedef struct packed
   {
      logic [GRAY_W-1:0]   bin;
      logic [GRAY_W-1:0]   gray;
   } sadc_link_t;

   sadc_ctl_t            q;
   sadc_ctl_t            d;
   sadc_link_t           lk_q;
   sadc_link_t           lk_d;

   logic                 rst_sync_n;
   logic                 cs_s;
   logic                 cmp_s;
   logic [GRAY_W-1:0]    gray_s;
   logic                 sar_busy;
   logic [RES_W-1:0]     sar_result;

   // ****************************************
   // gray to binary
   // ****************************************
   function automatic logic [GRAY_W-1:0] gray2bin(input logic [GRAY_W-1:0] g);
      logic [GRAY_W-1:0] b;
      b[GRAY_W-1] = g[GRAY_W-1];
      for (int i = GRAY_W - 2; i >= 0; i--)
      begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction : gray2bin

   // ****************************************
   // reset release
   // ****************************************
   sadc_sync #(
      .W       (1),
      .RST_VAL (1'b0)
   ) u_rst_sync (
      .clk   (clk_sys),
      .rst_n (rst_n),
      .d     (1'b1),
      .q     (rst_sync_n)
   );

   // ****************************************
   // pin synchronisers
   // ****************************************
   sadc_sync #(
      .W       (2),
      .RST_VAL (2'b10)
   ) u_pin_sync (
      .clk   (clk_sys),
      .rst_n (rst_sync_n),
      .d     ({cs_n, cmp_above}),
      .q     ({cs_s, cmp_s})
   );

   sadc_sync #(
      .W       (GRAY_W),
      .RST_VAL (4'h0)
   ) u_gray_sync (
      .clk   (clk_sys),
      .rst_n (rst_sync_n),
      .d     (lk_q.gray),
      .q     (gray_s)
   );

   // ****************************************
   // link domain: falling edge counter
   // ****************************************
   always_comb
   begin
      lk_d.bin  = lk_q.bin + 4'h1;
      lk_d.gray = lk_d.bin ^ (lk_d.bin >> 1);
   end

   always_ff @(negedge io_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         lk_q <= '{bin: 4'h0, gray: 4'h0};
      end
      else
      begin
         lk_q <= lk_d;
      end
   end

   // ****************************************
   // converter core
   // ****************************************
   sadc_sar #(
      .STEP_CYC (STEP_CYC)
   ) u_sar (
      .clk_sys   (clk_sys),
      .rst_n     (rst_sync_n),
      .start     (q.conv_start),
      .abort     (q.abort),
      .cmp_above (cmp_s),
      .busy      (sar_busy),
      .dac_code  (dac_code),
      .result    (sar_result)
   );

   // ****************************************
   // frame control
   // ****************************************
   always_comb
   begin
      logic             cs_fall;
      logic             cs_rise;
      logic             io_edge;
      logic [GRAY_W-1:0] bin_now;
      logic [CNT_W-1:0] nc;
      cs_fall      = 1'b0;
      cs_rise      = 1'b0;
      bin_now      = gray2bin(gray_s);
      io_edge      = (bin_now != q.last_bin);
      nc           = q.cnt + 5'h01;
      d            = q;
      d.conv_start = 1'b0;
      d.abort      = 1'b0;
      d.last_bin   = bin_now;

      // select debounce
      if (cs_s == q.cs_lvl)
      begin
         d.cs_cnt = 4'h0;
      end
      else if (q.cs_cnt == CS_CNT_LAST)
      begin
         d.cs_cnt = 4'h0;
         d.cs_lvl = cs_s;
         cs_fall  = !cs_s;
         cs_rise  = cs_s;
      end
      else
      begin
         d.cs_cnt = q.cs_cnt + 4'h1;
      end

      // time since the tenth edge
      if (q.tmr_run && (q.tmr != TMR_CONV))
      begin
         d.tmr = q.tmr + 8'h01;
      end

      case (q.st)
         ST_IDLE:
         begin
            d.oe     = 1'b0;
            d.sample = 1'b0;
            if (cs_fall)
            begin
               d.st      = ST_SHIFT;
               d.cnt     = 5'h00;
               d.sh      = sar_result;
               d.dout    = sar_result[RES_W-1];
               d.oe      = 1'b1;
               d.pend    = 1'b0;
               d.tmr     = 8'h00;
               d.tmr_run = 1'b0;
               d.abort   = 1'b1;
            end
         end
         ST_SHIFT:
         begin
            if (cs_rise)
            begin
               d.st      = ST_IDLE;
               d.oe      = 1'b0;
               d.sample  = 1'b0;
               d.pend    = 1'b0;
               if (q.cnt >= EDGE_HOLD)
               begin
                  d.slow = (q.tmr == TMR_CONV);
               end
            end
            else if (io_edge)
            begin
               d.cnt = nc;
               if (nc == EDGE_SAMPLE)
               begin
                  d.sample = 1'b1;
               end
               if (nc < EDGE_HOLD)
               begin
                  d.sh   = {q.sh[RES_W-2:0], 1'b0};
                  d.dout = q.sh[RES_W-2];
               end
               else
               begin
                  d.dout = 1'b0;
               end
               if (nc == EDGE_HOLD)
               begin
                  d.sample     = 1'b0;
                  d.conv_start = 1'b1;
                  d.tmr        = 8'h00;
                  d.tmr_run    = 1'b1;
                  d.pend       = 1'b0;
               end
               if (nc == EDGE_LAST)
               begin
                  d.cnt  = 5'h00;
                  d.slow = (q.tmr == TMR_CONV);
                  if (sar_busy)
                  begin
                     d.pend = 1'b1;
                  end
                  else
                  begin
                     d.sh   = sar_result;
                     d.dout = sar_result[RES_W-1];
                  end
               end
            end
            else if (q.pend && !sar_busy)
            begin
               d.pend = 1'b0;
               d.cnt  = 5'h00;
               d.sh   = sar_result;
               d.dout = sar_result[RES_W-1];
            end
            else if (q.tmr_run && (q.tmr == TMR_SYNC) && (q.cnt == EDGE_HOLD))
            begin
               d.pend = 1'b1;
               d.slow = 1'b0;
            end
         end
         default:
         begin
            d.st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         q <= '{st:         ST_IDLE,
                cnt:        5'h00,
                sh:         RESULT_RST,
                dout:       1'b0,
                oe:         1'b0,
                sample:     1'b0,
                tmr:        8'h00,
                tmr_run:    1'b0,
                pend:       1'b0,
                slow:       1'b0,
                cs_lvl:     1'b1,
                cs_cnt:     4'h0,
                last_bin:   4'h0,
                conv_start: 1'b0,
                abort:      1'b0};
      end
      else
      begin
         q <= d;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign dout      = q.dout;
   assign dout_oe   = q.oe;
   assign sample_en = q.sample;
   assign conv_busy = sar_busy;
   assign mode_slow = q.slow;
   assign result    = sar_result;

endmodule : sadc_top

// ---- sim/sadc_top_checker.sv ----
`timescale 1ns/1ps

module sadc_top_checker
   import sadc_pkg::*;
#(
   parameter int STEP_CYC = STEP_CYC_DEF
)
(
   // system
   input wire logic                  clk_sys,
   input wire logic                  rst_n,
   // serial link
   input wire logic                  cs_n,
   input wire logic                  io_clk,
   input wire logic                  dout,
   input wire logic                  dout_oe,
   // analog front end
   input wire logic                  cmp_above,
   input wire logic                  sample_en,
   input wire logic [sadc_pkg::RES_W-1:0] dac_code,
   // status
   input wire logic                  conv_busy,
   input wire logic                  mode_slow,
   input wire logic [sadc_pkg::RES_W-1:0] result
);
   localparam int BUSY_MAX = 10 * STEP_CYC + 2;
   logic [7:0]  hi_q;
   logic [7:0]  lo_q;
   logic [11:0] busy_q;

   // ****************************************
   // level counters
   // ****************************************
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hi_q   <= 8'h00;
         lo_q   <= 8'h00;
         busy_q <= 12'h000;
      end
      else
      begin
         hi_q   <= cs_n ? hi_q + {7'h00, hi_q != 8'hff} : 8'h00;
         lo_q   <= !cs_n ? lo_q + {7'h00, lo_q != 8'hff} : 8'h00;
         busy_q <= conv_busy ? busy_q + {11'h000, busy_q != 12'hfff} : 12'h000;
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   // ****************************************
   // properties
   // ****************************************
   a_float_idle: assert property (hi_q >= 8'h14 |-> !dout_oe)
      else $error("output driven while select high");
   a_oe_on_fall: assert property (lo_q >= 8'h16 |-> dout_oe)
      else $error("output not enabled after select low");
   a_msb_first: assert property ($rose(dout_oe) |-> dout == result[9])
      else $error("first bit is not result msb");
   a_sample_span: assert property ($rose(sample_en) |-> sample_en[*8])
      else $error("sampling window too short");
   a_ten_edges: assert property ($rose(conv_busy) |-> $past(sample_en, 2) && !$past(sample_en))
      else $error("conversion not started by sample hold");
   a_zero_tenth: assert property ($rose(conv_busy) |-> !dout && dout_oe)
      else $error("output not low after tenth edge");
   a_busy_bound: assert property (busy_q <= 12'(BUSY_MAX))
      else $error("conversion too long");
   a_result_load: assert property ($changed(result) |-> !conv_busy
      && ($past(conv_busy) || $past(conv_busy, 2)))
      else $error("result changed outside conversion end");
   a_first_weight: assert property ($rose(conv_busy) |-> dac_code == 10'h200)
      else $error("first trial is not the top weight");
endmodule : sadc_top_checker

bind sadc_top sadc_top_checker #(.STEP_CYC(STEP_CYC)) i_sadc_top_checker
(
   .clk_sys(clk_sys), .rst_n(rst_n), .cs_n(cs_n), .io_clk(io_clk), .dout(dout), .dout_oe(dout_oe),
   .cmp_above(cmp_above), .sample_en(sample_en), .dac_code(dac_code), .conv_busy(conv_busy),
   .mode_slow(mode_slow), .result(result)
);

// ---- sim/sadc_host.sv ----
`timescale 1ns/1ps

module sadc_host
(
   // link
   output logic      cs_n,
   output logic      io_clk,
   input  wire logic dout,
   input  wire logic dout_oe
);
   logic lclk;
   logic last_q;
   logic pin;

   initial
   begin
      lclk = 1'b0;
      forever #7.5 lclk = ~lclk;
   end

   initial
   begin
      cs_n   = 1'b1;
      io_clk = 1'b0;
      last_q = 1'b0;
   end

   // released line shows the inverse of its last level
   always @(posedge lclk) if (dout_oe) last_q <= dout;
   assign pin = dout_oe ? dout : ~last_q;

   task automatic waitn(input int n);
      repeat (n) @(posedge lclk);
   endtask : waitn

   task automatic set_cs(input logic v);
      @(posedge lclk);
      cs_n <= v;
   endtask : set_cs

   // one transfer of n clocks, 600 ns period, slow stops after the eleventh clock
   task automatic xfer(input int n, input bit slow, input bit hold, output logic [15:0] bits);
      bits = 16'h0000;
      if (cs_n)
      begin
         set_cs(1'b0);
         waitn(200);
      end
      for (int k = 0; k < n; k++)
      begin
         io_clk <= 1'b1;
         waitn(20);
         bits[15-k] = pin;
         io_clk <= 1'b0;
         waitn(20);
         if (slow && k == 10) waitn(1500);
      end
      if (!hold) set_cs(1'b1);
   endtask : xfer
endmodule : sadc_host

// ---- sim/tb_sadc_top.sv ----
`timescale 1ns/1ps

module tb_sadc_top;
   import sadc_pkg::*;
   typedef struct { logic [RES_W-1:0] vin; int n; bit slow; bit hold; } sadc_row_t;
   logic                 clk_sys;
   logic                 rst_n;
   logic                 cs_n;
   logic                 io_clk;
   logic                 dout;
   logic                 dout_oe;
   logic                 cmp_above;
   logic                 sample_en;
   logic [RES_W-1:0]     dac_code;
   logic                 conv_busy;
   logic                 mode_slow;
   logic [RES_W-1:0]     result;
   logic [RES_W-1:0]     vin;
   logic [RES_W-1:0]     prev;
   logic [15:0]          bits;
   int                   mismatches = 0;
   int                   n_tests = 0;
   // modes 1,3,5,3 toggled, then 2,2,4,6 held
   sadc_row_t rows [8] = '{'{10'h2a5, 10, 0, 0}, '{10'h3ff, 16, 0, 0}, '{10'h000, 12, 1, 0},
      '{10'h155, 11, 0, 0}, '{10'h0aa, 10, 0, 1}, '{10'h300, 10, 0, 1}, '{10'h1c3, 16, 0, 1},
      '{10'h2e7, 16, 1, 1}};

   sadc_top i_sadc_top (.clk_sys(clk_sys), .rst_n(rst_n), .cs_n(cs_n), .io_clk(io_clk), .dout(dout),
      .dout_oe(dout_oe), .cmp_above(cmp_above), .sample_en(sample_en), .dac_code(dac_code),
      .conv_busy(conv_busy), .mode_slow(mode_slow), .result(result));
   sadc_host i_sadc_host (.cs_n(cs_n), .io_clk(io_clk), .dout(dout), .dout_oe(dout_oe));

   initial
   begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   // comparator: trial code above input clears the bit
   always @(posedge clk_sys) cmp_above <= (dac_code > vin);

   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk16

   task automatic chk10(input logic [RES_W-1:0] got, input logic [RES_W-1:0] exp);
      chk16({6'h00, got}, {6'h00, exp});
   endtask : chk10

   task automatic chk1(input logic got, input logic exp);
      chk16({15'h0000, got}, {15'h0000, exp});
   endtask : chk1

   task automatic test_done;
      if (mismatches == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : test_done

   initial
   begin
      #3_000_000;
      mismatches++;
      test_done();
   end

   initial
   begin
      rst_n = 1'b0;
      vin = 10'h000;
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      chk1(dout_oe, 1'b0);
      chk1(conv_busy, 1'b0);
      chk10(result, RESULT_RST);
      prev = RESULT_RST;
      foreach (rows[i])
      begin
         @(posedge clk_sys) vin <= rows[i].vin;
         i_sadc_host.xfer(rows[i].n, rows[i].slow, rows[i].hold, bits);
         chk16(bits, {prev, 6'h00});
         repeat (250) @(posedge clk_sys);
         chk10(result, rows[i].vin);
         chk1(mode_slow, rows[i].slow);
         if (!rows[i].hold) chk1(dout_oe, 1'b0);
         prev = rows[i].vin;
      end
      i_sadc_host.set_cs(1'b1);
      repeat (250) @(posedge clk_sys);
      // select falls again in mid conversion
      @(posedge clk_sys) vin <= 10'h111;
      i_sadc_host.xfer(10, 0, 0, bits);
      chk16(bits, {prev, 6'h00});
      i_sadc_host.waitn(130);
      i_sadc_host.set_cs(1'b0);
      repeat (40) @(posedge clk_sys);
      chk1(conv_busy, 1'b0);
      repeat (80) @(posedge clk_sys);
      chk10(result, prev);
      i_sadc_host.xfer(10, 0, 0, bits);
      chk16(bits, {prev, 6'h00});
      repeat (250) @(posedge clk_sys);
      chk10(result, 10'h111);
      test_done();
   end
endmodule : tb_sadc_top
